// *** include/dcp_cfg.svh ***
// Constants for the dynamic configuration port: widths, cell map, reset
// values and timing counts. Included by the package and by design files.
//
// Functional notes
// - All port signals active high; bus bits numbered upward from bit 0.
// - Enable, write select, address and write data are registered on the rising edge.
// - Each enabled operation gets exactly one one-cycle completion strobe.
// - Read data arrives some cycles after enable; the strobe marks it valid.
// - Operation starts only with enable high; write select picks read or write.
// - Write data latched at end of enable cycle; cell updated before strobe.
// - On a read, read data holds the addressed cell while the strobe is high.
// - On configuration every cell takes its bit from the loaded image.
// - Every cell output drives the functional block's configuration directly.
// - Read-only status and write-only enables may share one address.

`ifndef DCP_CFG_SVH
`define DCP_CFG_SVH

// Port widths
`define DCP_ADDR_W       4
`define DCP_DATA_W       16

// Cell map: plain configuration cells sit at 0 .. CELL_COUNT-1
`define DCP_CELL_COUNT   14
`define DCP_ADDR_FUNC    4'he
`define DCP_ADDR_STAT    4'hf
`define DCP_STAT_WORDS   2

// Reset values
`define DCP_CELL_RESET   16'h0000
`define DCP_WORD_ZERO    16'h0000

// Wait states between acceptance and completion
`define DCP_WAIT_CYCLES  2
`define DCP_WAIT_CNT_W   2

`endif

// *** include/dcp_pkg.sv ***
// Types shared by the dynamic configuration port and its cell array.
// Assumes dcp_cfg.svh is on the include path.

`include "dcp_cfg.svh"

package dcp_pkg;

    typedef logic [`DCP_ADDR_W-1:0] addr_t;
    typedef logic [`DCP_DATA_W-1:0] word_t;
    typedef logic [`DCP_WAIT_CNT_W-1:0] wait_cnt_t;

    // One sampled port request
    typedef struct packed {
        logic  en;
        logic  we;
        addr_t addr;
        word_t wdata;
    } port_req_s;

    // Write into the cell array
    typedef struct packed {
        logic  en;
        addr_t addr;
        word_t data;
    } cell_write_s;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_WAIT
    } port_state_e;

endpackage

// *** src/config_cell_array.sv ***
// Flip-flop array of configuration cells with one write port and an image load.
// Assumes all inputs come from logic on clk_sys_i.

`timescale 1ns/100ps
`default_nettype none

`include "dcp_cfg.svh"

module config_cell_array (
    input  wire logic                                      clk_sys_i,
    input  wire logic                                      rst_b_i,
    input  wire logic                                      load_i,
    input  wire logic [`DCP_CELL_COUNT*`DCP_DATA_W-1:0]    image_i,
    input  wire dcp_pkg::cell_write_s                      wr_i,
    output logic      [`DCP_CELL_COUNT*`DCP_DATA_W-1:0]    cells_o
);

    dcp_pkg::word_t cells      [`DCP_CELL_COUNT];
    dcp_pkg::word_t next_cells [`DCP_CELL_COUNT];

    // Image load takes priority over a port write in the same cycle
    always_comb begin
        for (int i = 0; i < `DCP_CELL_COUNT; i++) begin
            next_cells[i] = cells[i];
            if (load_i) begin
                next_cells[i] = image_i[i*`DCP_DATA_W +: `DCP_DATA_W];
            end else if (wr_i.en && (32'(wr_i.addr) == i)) begin
                next_cells[i] = wr_i.data;
            end
        end
    end

    // Cell registers
    always_ff @(posedge clk_sys_i) begin
        for (int i = 0; i < `DCP_CELL_COUNT; i++) begin
            if (!rst_b_i) begin
                cells[i] <= `DCP_CELL_RESET;
            end else begin
                cells[i] <= next_cells[i];
            end
        end
    end

    // Each cell drives its slice of the configuration bus
    genvar g;
    generate
        for (g = 0; g < `DCP_CELL_COUNT; g++) begin : g_out
            assign cells_o[g*`DCP_DATA_W +: `DCP_DATA_W] = cells[g];
        end
    endgenerate

    a_image_load: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        load_i |=> (cells_o == $past(image_i)))
        else $error("cell array did not take the loaded image");

endmodule

`default_nettype wire

// *** src/dynamic_config_port.sv ***
// Dynamic configuration port: synchronous read/write access from fabric
// logic into the configuration cells of a functional block.
// Assumes all inputs are driven by logic on clk_sys_i; one operation at a time.

`timescale 1ns/100ps
`default_nettype none

`include "dcp_cfg.svh"

module dynamic_config_port (
    input  wire logic                                      clk_sys_i,
    input  wire logic                                      rst_b_i,
    input  wire logic                                      port_enable_i,
    input  wire logic                                      write_select_i,
    input  wire logic [`DCP_ADDR_W-1:0]                    cell_address_i,
    input  wire logic [`DCP_DATA_W-1:0]                    write_data_bus_i,
    output logic      [`DCP_DATA_W-1:0]                    read_data_bus_o,
    output logic                                           completion_strobe_o,
    input  wire logic                                      config_load_i,
    input  wire logic [`DCP_CELL_COUNT*`DCP_DATA_W-1:0]    config_image_i,
    input  wire logic [`DCP_STAT_WORDS*`DCP_DATA_W-1:0]    status_i,
    output logic      [`DCP_DATA_W-1:0]                    function_enable_o,
    output logic      [`DCP_CELL_COUNT*`DCP_DATA_W-1:0]    config_bits_o
);

    // Sampled port inputs
    dcp_pkg::port_req_s req;
    dcp_pkg::port_req_s next_req;

    // Sequencer state
    dcp_pkg::port_state_e state;
    dcp_pkg::port_state_e next_state;
    dcp_pkg::wait_cnt_t   wait_cnt;
    dcp_pkg::wait_cnt_t   next_wait_cnt;
    dcp_pkg::port_req_s   op;
    dcp_pkg::port_req_s   next_op;

    // Answer registers
    logic                 next_strobe;
    dcp_pkg::word_t       next_rd_data;
    dcp_pkg::word_t       next_func;

    // Cell array interface
    dcp_pkg::cell_write_s cell_wr;
    logic                 finish;

    // Reads a word from the address map: config cells, status, or zero
    function automatic dcp_pkg::word_t read_word(
        input dcp_pkg::addr_t                                   addr,
        input logic [`DCP_CELL_COUNT*`DCP_DATA_W-1:0]          cells,
        input logic [`DCP_STAT_WORDS*`DCP_DATA_W-1:0]          stat
    );
        dcp_pkg::word_t w;
        w = `DCP_WORD_ZERO;
        if (32'(addr) < `DCP_CELL_COUNT) begin
            w = cells[32'(addr)*`DCP_DATA_W +: `DCP_DATA_W];
        end else if (addr == `DCP_ADDR_FUNC) begin
            w = stat[0 +: `DCP_DATA_W];
        end else if (addr == `DCP_ADDR_STAT) begin
            w = stat[`DCP_DATA_W +: `DCP_DATA_W];
        end
        return w;
    endfunction

    // Tells whether an address names a writable configuration cell
    function automatic logic is_cfg_cell(input dcp_pkg::addr_t addr);
        return (32'(addr) < `DCP_CELL_COUNT);
    endfunction

    // Input register: enable, write select, address and write data sampled on the rising edge
    always_comb begin
        next_req.en    = port_enable_i;
        next_req.we    = write_select_i;
        next_req.addr  = cell_address_i;
        next_req.wdata = write_data_bus_i;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            req <= '0;
        end else begin
            req <= next_req;
        end
    end

    // Last wait cycle completes the operation
    assign finish = (state == dcp_pkg::ST_WAIT) && (wait_cnt == '0);

    // Sequencer: accept a request when idle, wait, then complete
    always_comb begin
        next_state    = state;
        next_wait_cnt = wait_cnt;
        next_op       = op;
        unique case (state)
            dcp_pkg::ST_IDLE: begin
                if (req.en) begin
                    next_op       = req;
                    next_wait_cnt = dcp_pkg::wait_cnt_t'(`DCP_WAIT_CYCLES - 1);
                    next_state    = dcp_pkg::ST_WAIT;
                end
            end
            dcp_pkg::ST_WAIT: begin
                if (wait_cnt == '0) begin
                    next_state = dcp_pkg::ST_IDLE;
                end else begin
                    next_wait_cnt = wait_cnt - 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            state    <= dcp_pkg::ST_IDLE;
            wait_cnt <= '0;
            op       <= '0;
        end else begin
            state    <= next_state;
            wait_cnt <= next_wait_cnt;
            op       <= next_op;
        end
    end

    // Cell write lands at the completion edge, before the strobe shows
    always_comb begin
        cell_wr.en   = finish && op.we && is_cfg_cell(op.addr);
        cell_wr.addr = op.addr;
        cell_wr.data = op.wdata;
    end

    config_cell_array u_cells (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .load_i    (config_load_i),
        .image_i   (config_image_i),
        .wr_i      (cell_wr),
        .cells_o   (config_bits_o)
    );

    // Answer: one-cycle strobe, read word, write-only function pulse
    always_comb begin
        next_strobe  = finish;
        next_rd_data = read_data_bus_o;
        next_func    = `DCP_WORD_ZERO;
        if (finish && !op.we) begin
            next_rd_data = read_word(op.addr, config_bits_o, status_i);
        end
        if (finish && op.we && (op.addr == `DCP_ADDR_FUNC)) begin
            next_func = op.wdata;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            completion_strobe_o <= 1'b0;
            read_data_bus_o     <= `DCP_WORD_ZERO;
            function_enable_o   <= `DCP_WORD_ZERO;
        end else begin
            completion_strobe_o <= next_strobe;
            read_data_bus_o     <= next_rd_data;
            function_enable_o   <= next_func;
        end
    end

    // Strobe is never longer than one cycle
    a_strobe_one_cycle: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        completion_strobe_o |=> !completion_strobe_o)
        else $error("completion strobe held longer than one cycle");

    // Accepted request completes after exactly the wait states
    a_strobe_latency: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (req.en && state == dcp_pkg::ST_IDLE) |->
            !completion_strobe_o [*1] ##1 !completion_strobe_o ##1 !completion_strobe_o
            ##1 completion_strobe_o)
        else $error("completion strobe not three cycles after acceptance");

    // Strobe only follows the last wait cycle
    a_strobe_cause: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        completion_strobe_o |-> ($past(state) == dcp_pkg::ST_WAIT && $past(wait_cnt) == '0))
        else $error("completion strobe without a pending operation");

    // Read data matches the addressed cell while the strobe is high
    a_read_data: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (completion_strobe_o && !op.we && is_cfg_cell(op.addr)) |->
            (read_data_bus_o == config_bits_o[32'(op.addr)*`DCP_DATA_W +: `DCP_DATA_W]))
        else $error("read data differs from addressed cell during strobe");

    // Written cell already holds its data when the strobe shows
    a_write_lands: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (completion_strobe_o && op.we && is_cfg_cell(op.addr) && !$past(config_load_i)) |->
            (config_bits_o[32'(op.addr)*`DCP_DATA_W +: `DCP_DATA_W] == op.wdata))
        else $error("write did not land before completion strobe");

    // Idle cycles without an enable start nothing
    a_idle_ignore: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (state == dcp_pkg::ST_IDLE && !req.en) |=> (state == dcp_pkg::ST_IDLE))
        else $error("operation started without port enable");

    // Cells change only through a completing write or an image load
    a_cells_stable: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (!finish && !config_load_i) |=> $stable(config_bits_o))
        else $error("configuration cells changed without a write");

    // Function enable pulses only with the strobe of a write to its address
    a_func_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (function_enable_o != `DCP_WORD_ZERO) |->
            (completion_strobe_o && op.we && op.addr == `DCP_ADDR_FUNC))
        else $error("function enable outside its write completion");

    // Sampled request mirrors the pins one cycle earlier
    a_input_sample: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        $past(rst_b_i) |-> (req.en == $past(port_enable_i) && req.addr == $past(cell_address_i)))
        else $error("port inputs not registered on the rising edge");

endmodule

`default_nettype wire

// *** verif/fabric_model.sv ***
// Fabric-side user logic that drives the configuration port.
// Assumes calls to its tasks are made just after a falling clock edge.
`timescale 1ns/100ps
`default_nettype none
`include "dcp_cfg.svh"

module fabric_model (
    input  wire logic                   clk_sys_i,
    input  wire logic                   completion_strobe_i,
    output logic                        port_enable_o,
    output logic                        write_select_o,
    output logic [`DCP_ADDR_W-1:0]      cell_address_o,
    output logic [`DCP_DATA_W-1:0]      write_data_bus_o
);
    // Idle bus: enable, write select, address and data all start at zero
    initial begin
        port_enable_o = 1'b0;
        write_select_o = 1'b0;
        cell_address_o = '0;
        write_data_bus_o = '0;
    end

    // Released address and data lines show the inverse; enable and write select go low
    task automatic release_bus();
        port_enable_o = 1'b0;
        write_select_o = 1'b0;
        cell_address_o = ~cell_address_o;
        write_data_bus_o = ~write_data_bus_o;
    endtask

    // One operation; returns at the falling edge of the strobe cycle
    task automatic op(input logic w, input logic [`DCP_ADDR_W-1:0] a,
                      input logic [`DCP_DATA_W-1:0] d, input bit rogue);
        int n;
        n = 0;
        port_enable_o = 1'b1;
        write_select_o = w;
        cell_address_o = a;
        write_data_bus_o = d;
        @(negedge clk_sys_i);
        release_bus();
        if (rogue) begin
            @(negedge clk_sys_i);
            port_enable_o = 1'b1; // Second enable while busy, on purpose
            @(negedge clk_sys_i);
            release_bus();
        end
        while (completion_strobe_i !== 1'b1 && n < 50) begin
            @(negedge clk_sys_i);
            n++;
        end
    endtask

    // Enable low while the other lines move
    task automatic idle_junk(input int n);
        repeat (n) begin
            write_select_o = 1'b1;
            cell_address_o = ~cell_address_o;
            write_data_bus_o = write_data_bus_o + 16'h1357;
            @(negedge clk_sys_i);
        end
        write_select_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// *** verif/dynamic_config_port_tb.sv ***
// Self-checking bench for the dynamic configuration port.
// Assumes fabric_model drives the port; expectations come from a cell model.
`timescale 1ns/100ps
`default_nettype none
`include "dcp_cfg.svh"

module dynamic_config_port_tb;
    localparam int IMG_W = `DCP_CELL_COUNT*`DCP_DATA_W;
    localparam int CELLS = `DCP_CELL_COUNT;
    typedef struct packed {logic we; logic [3:0] addr; logic [15:0] rd; logic [15:0] fe;
                           int cyc;} note_s;
    logic               clk_sys_i = 1'b0;
    logic               rst_b_i = 1'b0;
    logic               config_load_i = 1'b0;
    logic [IMG_W-1:0]   config_image_i = '0;
    logic [31:0]        status_i = '0;
    logic               en, we, strobe;
    logic [3:0]         addr;
    logic [15:0]        wdata, rdata, fe;
    logic [IMG_W-1:0]   bits;
    logic [15:0]        model [CELLS];
    note_s              notes[$];
    int                 errors = 0, num_checks = 0, cyc = 0, seed = 76, i;

    always #2.5 clk_sys_i = ~clk_sys_i;

    dynamic_config_port u_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .port_enable_i(en), .write_select_i(we), .cell_address_i(addr),
        .write_data_bus_i(wdata), .read_data_bus_o(rdata), .completion_strobe_o(strobe),
        .config_load_i(config_load_i), .config_image_i(config_image_i),
        .status_i(status_i), .function_enable_o(fe), .config_bits_o(bits));

    fabric_model u_fab (.clk_sys_i(clk_sys_i), .completion_strobe_i(strobe),
        .port_enable_o(en), .write_select_o(we), .cell_address_o(addr),
        .write_data_bus_o(wdata));

    task automatic chk(input string what, input logic [IMG_W-1:0] seen,
                       input logic [IMG_W-1:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Note the expected answer, then run the operation
    task automatic do_op(input logic w, input logic [3:0] a, input logic [15:0] d,
                         input bit rogue);
        note_s n;
        n.we = w;
        n.addr = a;
        n.cyc = cyc;
        n.fe = (w && a == `DCP_ADDR_FUNC) ? d : 16'h0000;
        n.rd = (a == `DCP_ADDR_FUNC) ? status_i[15:0] : status_i[31:16];
        if (a < CELLS) begin
            if (w) model[a] = d;
            n.rd = model[a];
        end
        notes.push_back(n);
        u_fab.op(w, a, d, rogue);
    endtask

    // Takes the oldest note whenever a strobe appears
    always @(posedge clk_sys_i) begin : monitor
        note_s n;
        cyc <= cyc + 1;
        if (strobe === 1'b1) begin
            if (notes.size() == 0) chk("stray strobe", 1, 0);
            else begin
                n = notes.pop_front();
                chk("latency", cyc - n.cyc, `DCP_WAIT_CYCLES + 2);
                if (!n.we) chk("read data", rdata, n.rd);
                chk("function enable", fe, n.fe);
                if (n.we && n.addr < CELLS) chk("cell", bits[n.addr*16 +: 16], n.rd);
            end
        end else if (fe !== 16'h0000) chk("function enable idle", fe, 0);
    end

    initial begin
        #100000;
        errors++;
        conclude();
    end

    initial begin
        repeat (10) @(negedge clk_sys_i);
        rst_b_i = 1'b1;
        @(negedge clk_sys_i);
        chk("reset cells", bits, 0);
        chk("reset strobe", strobe, 0);
        // Image load sets every cell
        for (i = 0; i < 7; i++) config_image_i[i*32 +: 32] = $random(seed);
        status_i = $random(seed);
        config_load_i = 1'b1;
        @(negedge clk_sys_i);
        config_load_i = 1'b0;
        chk("image", bits, config_image_i);
        for (i = 0; i < CELLS; i++) model[i] = config_image_i[i*16 +: 16];
        // Every address back to back
        for (i = 0; i < 16; i++) do_op(1'b0, 4'(i), 16'h0000, 1'b0);
        // Read-only and write-only places
        do_op(1'b1, `DCP_ADDR_STAT, 16'hffff, 1'b0);
        do_op(1'b0, `DCP_ADDR_STAT, 16'h0000, 1'b0);
        do_op(1'b1, `DCP_ADDR_FUNC, 16'h8001, 1'b0);
        // Random traffic, prompt and slow
        for (i = 0; i < 60; i++) begin
            do_op(1'($random(seed)), 4'($random(seed)), 16'($random(seed)), 1'b0);
            repeat ($random(seed) & 3) @(negedge clk_sys_i);
        end
        // Enable low: other lines must not matter
        u_fab.idle_junk(8);
        // Let an edge pass so write select is not driven twice in one step
        @(negedge clk_sys_i);
        for (i = 0; i < CELLS; i++) chk("idle cell", bits[i*16 +: 16], model[i]);
        // Enable during an outstanding operation is dropped
        do_op(1'b1, 4'h3, 16'ha5a5, 1'b1);
        do_op(1'b0, 4'h3, 16'h0000, 1'b0);
        repeat (8) @(negedge clk_sys_i);
        chk("notes left", notes.size(), 0);
        conclude();
    end
endmodule
`default_nettype wire
